/* tpg_core.v */
// Purpose: Pattern source with quarter-rate output and a simple error detector.
// Assumes: Link clock and receive nibble arrive from outside and are synchronised here.
// Notes: RAM patterns are stored once; replication to whole 256-bit rows is done
//        by wrapping the bit pointer, which yields the same serial stream.
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "tpg_defs.vh"

module tpg_core #(
    parameter RAM_WORDS = 64,
    parameter RAM_AW = 6,
    parameter FIFO_DEPTH = 16,
    parameter SYNC_TIMEOUT_CYC = `TPG_SYNC_TIME_MS * (`TPG_CLK_HZ / 1000)
) (
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire i_hready,
    input wire [31:0] i_hwdata,
    output reg [31:0] o_hrdata,
    output wire o_hreadyout,
    output wire o_hresp,
    input wire i_link_clk,
    input wire [3:0] i_rx_sub,
    output reg o_subrate_channel_zero,
    output reg o_subrate_channel_one,
    output reg o_subrate_channel_two,
    output reg o_subrate_channel_three,
    output reg o_trigger
);
    localparam ST_FILL = 1'b0;
    localparam ST_DRAIN = 1'b1;

    // Feedback bit of the selected Fibonacci generator.
    function fb_bit;
        input [30:0] s;
        input [2:0] sel;
        begin
            case (sel)
                `TPG_PRBS7: fb_bit = s[6] ^ s[5];
                `TPG_PRBS10: fb_bit = s[9] ^ s[6];
                `TPG_PRBS15: fb_bit = s[14] ^ s[13];
                `TPG_PRBS23: fb_bit = s[22] ^ s[17];
                default: fb_bit = s[30] ^ s[27];
            endcase
        end
    endfunction

    // Sequence length 2^n-1 of the selected generator.
    function [31:0] prbs_len;
        input [2:0] sel;
        begin
            case (sel)
                `TPG_PRBS7: prbs_len = 32'h0000_007F;
                `TPG_PRBS10: prbs_len = 32'h0000_03FF;
                `TPG_PRBS15: prbs_len = 32'h0000_7FFF;
                `TPG_PRBS23: prbs_len = 32'h007F_FFFF;
                default: prbs_len = 32'h7FFF_FFFF;
            endcase
        end
    endfunction

    // Copies needed for a length to fill whole 256-bit rows.
    function [8:0] reps_of;
        input [31:0] len;
        integer k;
        reg done;
        begin
            reps_of = 9'h100;
            done = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (!done && len[k] == 1'b0) begin
                    reps_of = reps_of >> 1;
                end else begin
                    done = 1'b1;
                end
            end
        end
    endfunction

    // Channel c takes serial bit 4k+c+pos-4, so position 1 puts each nibble's first bit
    // on channel three and the next three bits on channels zero to two.
    function [3:0] rot_nib;
        input [3:0] cur;
        input [3:0] prev;
        input [1:0] pos;
        reg [7:0] cat;
        begin
            cat = {cur, prev} >> pos;
            rot_nib = cat[3:0];
        end
    endfunction

    // Number of ones in a nibble.
    function [2:0] ones4;
        input [3:0] v;
        begin
            ones4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
        end
    endfunction

    // Register file.
    reg [7:0] ctrl_q;
    reg [31:0] pat_len_q;
    reg [RAM_AW-1:0] ram_addr_q;
    reg [7:0] sync_thr_q;
    reg [7:0] eye_thr_q;
    reg [31:0] err_cnt_q;
    reg [31:0] trig_cnt_q;
    reg [31:0] ram_q [0:RAM_WORDS-1];
    reg sync_q, loss_q, eye_q, tout_q, under_q;
    reg ph_wr_q, ph_act_q;
    reg [7:0] ph_addr_q;
    wire addr_ok;
    wire run;
    wire ram_mode;
    wire [2:0] sel;
    wire [1:0] pos;
    wire [8:0] reps;
    wire [31:0] clr_mask;

    assign run = ctrl_q[`TPG_CTRL_RUN];
    assign ram_mode = ctrl_q[`TPG_CTRL_RAM];
    assign sel = ctrl_q[`TPG_CTRL_SEL_HI:`TPG_CTRL_SEL_LO];
    assign pos = ctrl_q[`TPG_CTRL_POS_HI:`TPG_CTRL_POS_LO];
    assign reps = reps_of(pat_len_q);
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign addr_ok = i_hsel && i_htrans[1] && i_hready;
    assign clr_mask = (ph_act_q && ph_wr_q && ph_addr_q == `TPG_OFS_STATUS) ? i_hwdata : 32'h0;

    // Address phase capture and read data, answered with no wait states.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            ph_act_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
            o_hrdata <= 32'h0;
        end else begin
            ph_act_q <= addr_ok;
            ph_wr_q <= i_hwrite;
            ph_addr_q <= i_haddr[7:0];
            if (addr_ok && !i_hwrite) begin
                case (i_haddr[7:0])
                    `TPG_OFS_CTRL: o_hrdata <= {24'h0, ctrl_q};
                    `TPG_OFS_PAT_LEN: o_hrdata <= pat_len_q;
                    `TPG_OFS_RAM_ADDR: o_hrdata <= {{(32-RAM_AW){1'b0}}, ram_addr_q};
                    `TPG_OFS_SYNC_THR: o_hrdata <= {24'h0, sync_thr_q};
                    `TPG_OFS_EYE_THR: o_hrdata <= {24'h0, eye_thr_q};
                    `TPG_OFS_STATUS: o_hrdata <= {27'h0, under_q, tout_q, eye_q, loss_q, sync_q};
                    `TPG_OFS_ERR_CNT: o_hrdata <= err_cnt_q;
                    `TPG_OFS_TRIG_CNT: o_hrdata <= trig_cnt_q;
                    `TPG_OFS_REPS: o_hrdata <= {23'h0, reps};
                    default: o_hrdata <= 32'h0;
                endcase
            end
        end
    end

    // Data phase writes; the pattern RAM data port auto-increments its address.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            ctrl_q <= 8'h00;
            pat_len_q <= `TPG_RST_PAT_LEN;
            ram_addr_q <= {RAM_AW{1'b0}};
            sync_thr_q <= `TPG_RST_SYNC_THR;
            eye_thr_q <= `TPG_RST_EYE_THR;
        end else if (ph_act_q && ph_wr_q) begin
            case (ph_addr_q)
                `TPG_OFS_CTRL: ctrl_q <= i_hwdata[7:0];
                `TPG_OFS_PAT_LEN: pat_len_q <= i_hwdata;
                `TPG_OFS_RAM_ADDR: ram_addr_q <= i_hwdata[RAM_AW-1:0];
                `TPG_OFS_RAM_DATA: ram_addr_q <= ram_addr_q + 1'b1;
                `TPG_OFS_SYNC_THR: sync_thr_q <= i_hwdata[7:0];
                `TPG_OFS_EYE_THR: eye_thr_q <= i_hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Pattern RAM word store.
    always @(posedge i_clk_sys) begin
        if (ph_act_q && ph_wr_q && ph_addr_q == `TPG_OFS_RAM_DATA) begin
            ram_q[ram_addr_q] <= i_hwdata;
        end
    end

    // Word builder: PRBS loads 32 bits at once, RAM shifts in one bit per cycle.
    reg bst_q;
    reg [31:0] word_q;
    reg [5:0] fill_q;
    reg [3:0] nib_q;
    reg [30:0] lfsr_q;
    reg [31:0] ptr_q;
    reg [31:0] step_q;
    reg [31:0] rep_q;
    reg [31:0] gen_word;
    reg [30:0] gen_state;
    reg ram_bit;
    wire fifo_in_ready;
    wire [31:0] frame_bits;
    integer b;

    assign frame_bits = pat_len_q * {23'h0, reps};

    // One 32-bit step of the selected generator.
    always @* begin
        gen_state = lfsr_q;
        gen_word = 32'h0;
        for (b = 0; b < `TPG_WORD_BITS; b = b + 1) begin
            gen_word[b] = fb_bit(gen_state, sel);
            gen_state = {gen_state[29:0], gen_word[b]};
        end
        ram_bit = ram_q[ptr_q[RAM_AW+4:5]][ptr_q[4:0]];
    end

    // Builder state machine and trigger generation.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b || !run) begin
            bst_q <= ST_FILL;
            word_q <= 32'h0;
            fill_q <= 6'h00;
            nib_q <= 4'h0;
            lfsr_q <= `TPG_PRBS_SEED;
            ptr_q <= 32'h0;
            step_q <= 32'h0;
            rep_q <= 32'h0;
            o_trigger <= 1'b0;
            if (!i_rst_b) begin
                trig_cnt_q <= 32'h0;
            end
        end else begin
            o_trigger <= 1'b0;
            case (bst_q)
                ST_FILL: begin
                    if (!ram_mode) begin
                        word_q <= gen_word;
                        lfsr_q <= gen_state;
                        nib_q <= `TPG_NIBBLES;
                        bst_q <= ST_DRAIN;
                        // 2^n-1 steps of 32 bits hold exactly 32 whole sequences.
                        if (step_q >= prbs_len(sel) - 32'h1) begin
                            step_q <= 32'h0;
                            o_trigger <= 1'b1;
                            trig_cnt_q <= trig_cnt_q + 32'h1;
                        end else begin
                            step_q <= step_q + 32'h1;
                        end
                    end else begin
                        word_q <= {ram_bit, word_q[31:1]};
                        // Wrapping at the length repeats the pattern end to end.
                        ptr_q <= (ptr_q >= pat_len_q - 32'h1) ? 32'h0 : ptr_q + 32'h1;
                        if (rep_q >= frame_bits - 32'h1) begin
                            rep_q <= 32'h0;
                            o_trigger <= 1'b1;
                            trig_cnt_q <= trig_cnt_q + 32'h1;
                        end else begin
                            rep_q <= rep_q + 32'h1;
                        end
                        if (fill_q == 6'h1F) begin
                            fill_q <= 6'h00;
                            nib_q <= `TPG_NIBBLES;
                            bst_q <= ST_DRAIN;
                        end else begin
                            fill_q <= fill_q + 6'h01;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (fifo_in_ready) begin
                        word_q <= word_q >> 4;
                        nib_q <= nib_q - 4'h1;
                        if (nib_q == 4'h1) begin
                            bst_q <= ST_FILL;
                        end
                    end
                end
                default: bst_q <= ST_FILL;
            endcase
        end
    end

    // Nibble FIFO between the builder and the link side.
    wire fifo_out_valid;
    wire [3:0] fifo_out_data;
    reg link_s1_q, link_s2_q, link_s3_q;
    reg [3:0] rx_s1_q, rx_s2_q;
    wire link_tick;

    assign link_tick = link_s2_q && !link_s3_q;

    tpg_fifo #(
        .WIDTH(4),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_in_valid(bst_q == ST_DRAIN && run),
        .o_in_ready(fifo_in_ready),
        .i_in_data(word_q[3:0]),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(link_tick),
        .o_out_data(fifo_out_data)
    );

    // Two-flop synchronisers for the link clock and receive nibble.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            link_s1_q <= 1'b0;
            link_s2_q <= 1'b0;
            link_s3_q <= 1'b0;
            rx_s1_q <= 4'h0;
            rx_s2_q <= 4'h0;
        end else begin
            link_s1_q <= i_link_clk;
            link_s2_q <= link_s1_q;
            link_s3_q <= link_s2_q;
            rx_s1_q <= i_rx_sub;
            rx_s2_q <= rx_s1_q;
        end
    end

    // Output stage: one rotated nibble per link edge, one bit per channel.
    reg [3:0] prev_q;
    reg [31:0] hist_q;
    wire [3:0] tx_nib;

    assign tx_nib = rot_nib(fifo_out_data, prev_q, pos);

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            prev_q <= 4'h0;
            hist_q <= 32'h0;
            o_subrate_channel_zero <= 1'b0;
            o_subrate_channel_one <= 1'b0;
            o_subrate_channel_two <= 1'b0;
            o_subrate_channel_three <= 1'b0;
        end else if (link_tick && fifo_out_valid) begin
            prev_q <= fifo_out_data;
            hist_q <= {hist_q[27:0], tx_nib};
            o_subrate_channel_zero <= tx_nib[0];
            o_subrate_channel_one <= tx_nib[1];
            o_subrate_channel_two <= tx_nib[2];
            o_subrate_channel_three <= tx_nib[3];
        end
    end

    // Error detector: compare against a lagged copy, slip the lag while out of sync.
    reg [2:0] lag_q;
    reg [5:0] win_q;
    reg [8:0] win_err_q;
    reg [31:0] hunt_q;
    wire [3:0] ref_nib;
    wire [2:0] bit_err;
    wire [8:0] win_sum;

    assign ref_nib = hist_q[{lag_q, 2'b00} +: 4];
    assign bit_err = ones4(rx_s2_q ^ ref_nib);
    assign win_sum = win_err_q + {6'h0, bit_err};

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            lag_q <= 3'h0;
            win_q <= 6'h00;
            win_err_q <= 9'h000;
            err_cnt_q <= 32'h0;
            hunt_q <= 32'h0;
            sync_q <= 1'b0;
            loss_q <= 1'b0;
            eye_q <= 1'b0;
            tout_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            // Write one to a loss, eye, timeout or underrun bit clears it (sync is not cleared); a new event in that cycle wins.
            loss_q <= loss_q & ~clr_mask[`TPG_ST_LOSS];
            eye_q <= eye_q & ~clr_mask[`TPG_ST_EYE];
            tout_q <= tout_q & ~clr_mask[`TPG_ST_TOUT];
            under_q <= (under_q & ~clr_mask[`TPG_ST_UNDER]) | (run && link_tick && !fifo_out_valid);
            if (!run || sync_q) begin
                hunt_q <= 32'h0;
            end else if (hunt_q >= SYNC_TIMEOUT_CYC - 1) begin
                tout_q <= 1'b1;
            end else begin
                hunt_q <= hunt_q + 32'h1;
            end
            if (run && link_tick && fifo_out_valid) begin
                if (sync_q) begin
                    err_cnt_q <= err_cnt_q + {29'h0, bit_err};
                end
                if (win_q == `TPG_WIN_NIBBLES) begin
                    win_q <= 6'h00;
                    win_err_q <= 9'h000;
                    if (ctrl_q[`TPG_CTRL_ALIGN] && win_sum > {1'b0, eye_thr_q}) begin
                        eye_q <= 1'b1;
                    end
                    if (win_sum < {1'b0, sync_thr_q}) begin
                        sync_q <= 1'b1;
                    end else begin
                        if (sync_q) begin
                            loss_q <= 1'b1;
                        end
                        sync_q <= 1'b0;
                        lag_q <= lag_q + 3'h1;
                    end
                end else begin
                    win_q <= win_q + 6'h01;
                    win_err_q <= win_sum;
                end
            end
        end
    end
endmodule // tpg_core

/* tpg_core_monitor.sv */
// Purpose: Port checks of the pattern generator core.
// Assumes: One clock; synchronous active-low reset.
// Notes: Link edges are found by sampling the raw link clock.
`timescale 1ns/100ps
`include "tpg_defs.vh"
module tpg_core_monitor (
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    input wire [31:0] o_hrdata,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire i_link_clk,
    input wire o_subrate_channel_zero,
    input wire o_subrate_channel_one,
    input wire o_subrate_channel_two,
    input wire o_subrate_channel_three,
    input wire o_trigger
);
    reg link_q;
    reg [3:0] since_q;
    wire rd_ph = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
    wire [7:0] ofs = i_haddr[7:0];
    wire [3:0] chans = {o_subrate_channel_three, o_subrate_channel_two,
        o_subrate_channel_one, o_subrate_channel_zero};
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // Counts system cycles since the link clock was last seen rising.
    always @(posedge i_clk_sys) begin
        link_q <= i_link_clk;
        if (!i_rst_b) since_q <= 4'hF;
        else if (i_link_clk && !link_q) since_q <= 4'h0;
        else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
    a_ready_high: assert property (o_hreadyout == 1'b1)
        else $error("hreadyout low");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("hresp not okay");
    a_chan_on_link: assert property ($changed(chans) |-> since_q >= 4'h2 && since_q <= 4'h5)
        else $error("channels moved away from a link edge");
    a_trigger_single: assert property (o_trigger |=> !o_trigger [*8])
        else $error("trigger longer than one cycle");
    a_rd_unmapped: assert property (rd_ph && ofs > `TPG_OFS_REPS |=> o_hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_rd_ramdata: assert property (rd_ph && ofs == `TPG_OFS_RAM_DATA |=> o_hrdata == 32'h0)
        else $error("pattern data port read not zero");
    a_reps_pow2: assert property (rd_ph && ofs == `TPG_OFS_REPS |=>
        $onehot(o_hrdata) && o_hrdata <= 32'h0000_0100) else $error("copy count bad");
    a_status_spare: assert property (rd_ph && ofs == `TPG_OFS_STATUS |=>
        o_hrdata[31:5] == 27'h0) else $error("status spare bits set");
    a_rdata_holds: assert property ($changed(o_hrdata) |-> $past(rd_ph))
        else $error("read data moved without a read");
endmodule // tpg_core_monitor
bind tpg_core tpg_core_monitor u_tpg_core_monitor (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_link_clk(i_link_clk), .o_subrate_channel_zero(o_subrate_channel_zero),
    .o_subrate_channel_one(o_subrate_channel_one), .o_subrate_channel_two(o_subrate_channel_two),
    .o_subrate_channel_three(o_subrate_channel_three), .o_trigger(o_trigger));

/* tpg_core_tb_top.sv */
// Purpose: Self-checking bench of the pattern generator core.
// Assumes: 10 MHz system clock; link clock comes from the partner model.
// Notes: Expectations come from an integer model of patterns and registers.
`timescale 1ns/100ps
`include "tpg_defs.vh"
module tpg_core_tb_top;
    reg clk_sys, rst_b, hsel, hwrite, corrupt;
    reg [31:0] haddr;
    reg [1:0] htrans;
    reg [31:0] hwdata;
    wire [31:0] hrdata;
    wire hreadyout, hresp, link_clk, trig;
    wire [3:0] rx_sub, ch;
    int num_errors = 0;
    int n_compared = 0;
    int seed = 67;
    int i, j, per, o0, o1;
    logic [31:0] v;
    logic pat [0:63];
    logic q_bits [$];
    int rst_tbl [0:9] = '{0, `TPG_RST_PAT_LEN, 0, 0, `TPG_RST_SYNC_THR, `TPG_RST_EYE_THR,
        0, 0, 0, 1};
    int tap_a [0:4] = '{7, 10, 15, 23, 31};
    int tap_b [0:4] = '{6, 7, 14, 18, 28};
    int lens [0:3] = '{256, 512, 12, 1};
    tpg_core #(.SYNC_TIMEOUT_CYC(2000)) u_tpg_core (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hready(hreadyout), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .i_link_clk(link_clk), .i_rx_sub(rx_sub),
        .o_subrate_channel_zero(ch[0]), .o_subrate_channel_one(ch[1]),
        .o_subrate_channel_two(ch[2]), .o_subrate_channel_three(ch[3]), .o_trigger(trig));
    tpg_dut_model u_tpg_dut_model (.i_ch(ch), .i_corrupt(corrupt), .o_link_clk(link_clk),
        .o_rx_sub(rx_sub));
    // Makes the system clock.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic give_verdict;
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One single bus transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, a, d, t);
    endtask
    task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] t;
        bus(1'b0, a, 32'h0, t);
        check(name, t, exp);
        check("hresp", hresp, 32'h0);
    endtask
    // Samples n nibbles, well after each link edge, as serial bits.
    task automatic capture(input int n);
        logic [3:0] nib;
        q_bits.delete();
        repeat (n) begin
            @(posedge link_clk);
            repeat (6) @(posedge clk_sys);
            nib = ch;
            for (int c = 0; c < 4; c++) q_bits.push_back(nib[c]);
        end
    endtask
    function automatic int find_off(input int len);
        for (int o = 0; o < len; o++) begin
            int ok;
            ok = 1;
            foreach (q_bits[k]) if (q_bits[k] !== pat[(k + o) % len]) ok = 0;
            if (ok == 1) return o;
        end
        return -1;
    endfunction
    function automatic int reps_of(input int len);
        int r;
        r = 256;
        while (r > 1 && len % 2 == 0) begin
            r = r / 2;
            len = len / 2;
        end
        return r;
    endfunction
    task automatic trig_period(output int cnt);
        @(posedge clk_sys);
        while (trig !== 1'b1) @(posedge clk_sys);
        cnt = 0;
        do begin
            @(posedge clk_sys);
            cnt++;
        end while (trig !== 1'b1);
    endtask
    task automatic run_ram(input int len, input int pos, output int off);
        int cnt;
        wr(`TPG_OFS_CTRL, 32'h0);
        wr(`TPG_OFS_PAT_LEN, len);
        rchk("reps", `TPG_OFS_REPS, reps_of(len));
        wr(`TPG_OFS_CTRL, 32'h3 | (pos << 5));
        trig_period(cnt);
        trig_period(cnt);
        check("ram_trig_period", cnt, len * reps_of(len) * 2);
        capture(16);
        off = find_off(len);
    endtask
    task automatic wait_sync;
        logic [31:0] s;
        s = 32'h0;
        for (int k = 0; k < 100 && s[0] !== 1'b1; k++) begin
            repeat (100) @(posedge clk_sys);
            bus(1'b0, `TPG_OFS_STATUS, 32'h0, s);
        end
        check("sync", s[0], 32'h1);
    endtask
    // Cuts a hung run short.
    initial begin
        repeat (95000) @(posedge clk_sys);
        num_errors++;
        give_verdict;
    end
    // Main sequence: registers, RAM playout, generators, detector.
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        corrupt = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (i = 0; i < 10; i++) if (i != 6) rchk("reset", 4 * i, rst_tbl[i]);
        rchk("unmapped", 32'h40, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr(`TPG_OFS_PAT_LEN, lens[i]);
            rchk("reps", `TPG_OFS_REPS, reps_of(lens[i]));
        end
        wr(`TPG_OFS_RAM_ADDR, 32'h0);
        for (i = 0; i < 2; i++) begin
            v = $random(seed);
            wr(`TPG_OFS_RAM_DATA, v);
            for (j = 0; j < 32; j++) pat[32 * i + j] = v[j];
        end
        rchk("ram_addr", `TPG_OFS_RAM_ADDR, 32'h2);
        run_ram(20, 0, o0);
        run_ram(20, 1, o1);
        check("stream_found", o0 >= 0, 32'h1);
        check("pos0_phase", o0 % 4, 32'h0);
        check("pos1_rotation", o1 % 4, 32'h1);
        run_ram(7, 0, o0);
        check("odd_stream", o0 >= 0, 32'h1);
        for (i = 0; i < 5; i++) begin
            wr(`TPG_OFS_CTRL, 32'h0);
            wr(`TPG_OFS_CTRL, 32'h1 | (i << 2));
            repeat (24) @(posedge link_clk);
            capture(64);
            per = 0;
            o0 = 0;
            for (j = 31; j < 256; j++) begin
                if (q_bits[j] !== (q_bits[j - tap_a[i]] ^ q_bits[j - tap_b[i]])) per++;
                if (q_bits[j] === 1'b1) o0++;
            end
            check("prbs_taps", per, 32'h0);
            check("prbs_live", o0 > 0, 32'h1);
        end
        wr(`TPG_OFS_CTRL, 32'h1);
        trig_period(per);
        trig_period(per);
        check("prbs_trig_period", per, 127 * `TPG_WORD_BITS * 2);
        wait_sync;
        wr(`TPG_OFS_STATUS, 32'h1E);
        rchk("status_clean", `TPG_OFS_STATUS, 32'h1);
        wr(`TPG_OFS_EYE_THR, 32'h1);
        wr(`TPG_OFS_CTRL, 32'h81);
        corrupt <= 1'b1;
        repeat (3500) @(posedge clk_sys);
        rchk("status_bad", `TPG_OFS_STATUS, 32'hE);
        bus(1'b0, `TPG_OFS_ERR_CNT, 32'h0, v);
        check("err_counted", v != 0, 32'h1);
        corrupt <= 1'b0;
        wr(`TPG_OFS_CTRL, 32'h1);
        wait_sync;
        wr(`TPG_OFS_STATUS, 32'h1E);
        rchk("status_resync", `TPG_OFS_STATUS, 32'h1);
        wr(`TPG_OFS_CTRL, 32'h0);
        repeat (400) @(posedge clk_sys);
        wr(`TPG_OFS_CTRL, 32'h1);
        repeat (40) @(posedge clk_sys);
        bus(1'b0, `TPG_OFS_STATUS, 32'h0, v);
        check("underrun", v[4], 32'h1);
        give_verdict;
    end
endmodule // tpg_core_tb_top

/* tpg_defs.vh */
// Purpose: Shared constants of the test pattern generator: register map, fields, resets, timing.
// Assumes: A 10 MHz system clock and an AHB-Lite register bus with 32-bit words.
// Notes: Offsets are byte addresses of aligned words.
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH

// Register byte offsets.
`define TPG_OFS_CTRL 8'h00
`define TPG_OFS_PAT_LEN 8'h04
`define TPG_OFS_RAM_ADDR 8'h08
`define TPG_OFS_RAM_DATA 8'h0C
`define TPG_OFS_SYNC_THR 8'h10
`define TPG_OFS_EYE_THR 8'h14
`define TPG_OFS_STATUS 8'h18
`define TPG_OFS_ERR_CNT 8'h1C
`define TPG_OFS_TRIG_CNT 8'h20
`define TPG_OFS_REPS 8'h24

// Control register fields.
`define TPG_CTRL_RUN 0
`define TPG_CTRL_RAM 1
`define TPG_CTRL_SEL_LO 2
`define TPG_CTRL_SEL_HI 4
`define TPG_CTRL_POS_LO 5
`define TPG_CTRL_POS_HI 6
`define TPG_CTRL_ALIGN 7

// Status register fields.
`define TPG_ST_SYNC 0
`define TPG_ST_LOSS 1
`define TPG_ST_EYE 2
`define TPG_ST_TOUT 3
`define TPG_ST_UNDER 4

// Pseudo-random sequence selections.
`define TPG_PRBS7 3'h0
`define TPG_PRBS10 3'h1
`define TPG_PRBS15 3'h2
`define TPG_PRBS23 3'h3
`define TPG_PRBS31 3'h4

// Reset values.
`define TPG_RST_PAT_LEN 32'h0000_0100
`define TPG_RST_SYNC_THR 8'h04
`define TPG_RST_EYE_THR 8'h20
`define TPG_PRBS_SEED 31'h7FFF_FFFF

// Geometry and timing.
`define TPG_RAM_ROW_BITS 256
`define TPG_WORD_BITS 32
`define TPG_NIBBLES 4'h8
`define TPG_WIN_NIBBLES 6'h3F
`define TPG_CLK_HZ 10000000
`define TPG_SYNC_TIME_MS 3000

`endif

/* tpg_dut_model.sv */
// Purpose: Device under test that loops the quarter-rate data back.
// Assumes: Free-running 800 ns link clock, phase unrelated to the system clock.
// Notes: Corruption inverts every returned bit while commanded.
`timescale 1ns/100ps
module tpg_dut_model (
    input wire [3:0] i_ch,
    input wire i_corrupt,
    output reg o_link_clk,
    output reg [3:0] o_rx_sub
);
    // Makes the link clock with an odd phase offset.
    initial begin
        o_link_clk = 1'b0;
        o_rx_sub = 4'h0;
        #37;
        forever #400 o_link_clk = ~o_link_clk;
    end
    // Returns the nibble seen at each link rising edge.
    always @(posedge o_link_clk) begin
        o_rx_sub <= i_ch ^ {4{i_corrupt}};
    end
endmodule // tpg_dut_model

/* tpg_fifo.v */
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; depth is a power of two.
// Notes: Read data comes straight from the storage word under the read pointer.
`timescale 1ns/100ps
module tpg_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire push;
    wire pop;

    // Full and empty come from pointers with one wrap bit.
    assign o_in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign o_out_valid = (wr_q != rd_q);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_q[rd_q[AW-1:0]];

    // Storage write, no reset needed on the data words.
    always @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    // Pointer update.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // tpg_fifo
